// >>> shared/ctt_pkg.sv
// Constants, register map and carrier types of the core timebase and timers block
// Operation
// - A free-running 64-bit time base feeds all three timers.
// - Time base counts ticks from the clock rate or an external timer clock.
// - Time base wrap to zero raises no interrupt.
// - Interval counter, fixed-period tick and guard timer all use the time base tick.
// - Interval down-counter is 32 bits, loaded by software, decrements per tick.
// - At zero the interval counter stops and raises its interrupt.
// - With auto-reload, zero reloads the last written value and counting continues.
// - Fixed-period tick watches one of four selectable time base bits.
// - Fixed-period interrupt on rising edge of chosen bit only.
// - Guard timer raises a periodic critical interrupt from a chosen time base bit.
// - Guard interval selects one of four periods; reset kind is configurable.
// - Without software clear within two guard intervals, the selected reset issues.
`default_nettype none
package ctt_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   // Register word addresses
   localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
   localparam logic [ADDR_W-1:0] REG_TB_LO  = 4'h1;
   localparam logic [ADDR_W-1:0] REG_TB_HI  = 4'h2;
   localparam logic [ADDR_W-1:0] REG_IDC    = 4'h3;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] REG_MASK   = 4'h5;
   localparam logic [ADDR_W-1:0] REG_GUARD  = 4'h6;
   // Control field positions
   localparam int CTRL_TB_EN     = 0;
   localparam int CTRL_EXT_SEL   = 1;
   localparam int CTRL_RELOAD    = 2;
   localparam int CTRL_FPT_SEL   = 4;
   localparam int CTRL_LGT_SEL   = 6;
   localparam int CTRL_LGT_EN    = 8;
   localparam int CTRL_RST_KIND  = 9;
   localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0001;
   // Status bits
   localparam int ST_IDC = 0;
   localparam int ST_FPT = 1;
   localparam int ST_LGT = 2;
   localparam int ST_W   = 3;
   // Guard register bit: write 1 to clear the guard stage
   localparam int GUARD_CLR = 0;
   // Time base bit taps for the four choices of the fixed-period and guard timers
   localparam int FPT_TAP0 = 9;
   localparam int FPT_TAP1 = 13;
   localparam int FPT_TAP2 = 17;
   localparam int FPT_TAP3 = 21;
   localparam int LGT_TAP0 = 17;
   localparam int LGT_TAP1 = 21;
   localparam int LGT_TAP2 = 25;
   localparam int LGT_TAP3 = 29;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } ctt_bus_req_t;

   typedef enum logic [1:0] {
      RST_NONE,
      RST_CORE,
      RST_CHIP,
      RST_SYSTEM
   } ctt_rst_kind_t;

   typedef enum {
      LGT_IDLE,
      LGT_FIRST,
      LGT_SECOND
   } ctt_lgt_state_t;
endpackage
`default_nettype wire

// >>> hw/ctt_timers.sv
// Time base, interval down-counter, fixed-period tick and lockup guard timer
`default_nettype none
module ctt_timers
   import ctt_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_srst,
   // External timer clock pin
   input  wire logic              i_ext_tick_clk,
   // Register port
   input  wire ctt_bus_req_t      i_bus,
   output logic [DATA_W-1:0]      o_rdata,
   // Interrupts and reset request
   output logic                   o_irq,
   output logic                   o_critical_irq,
   output logic                   o_reset_req,
   output logic [1:0]             o_reset_kind
);
   logic [DATA_W-1:0] ctrl;
   logic [63:0]       time_base;
   logic [31:0]       interval_down_counter;
   logic [31:0]       reload_value;
   logic [ST_W-1:0]   status;
   logic [ST_W-1:0]   mask;
   logic [2:0]        ext_sync;
   logic              tick;
   logic              fpt_bit_q;
   logic              lgt_bit_q;
   logic              fpt_bit;
   logic              lgt_bit;
   logic              idc_event;
   logic              fpt_event;
   logic              lgt_event;
   logic              rd_status;
   logic              guard_clear;
   ctt_lgt_state_t    lgt_state;

   // Pin is synchronised; only the second and third stages feed the edge detect
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         ext_sync <= 3'h0;
      end else begin
         ext_sync <= {ext_sync[1:0], i_ext_tick_clk};
      end
   end

   // One tick per clock, or per rising edge of the external timer clock
   always_comb begin
      if (ctrl[CTRL_EXT_SEL]) begin
         tick = ctrl[CTRL_TB_EN] & ext_sync[1] & ~ext_sync[2];
      end else begin
         tick = ctrl[CTRL_TB_EN];
      end
   end

   // Free-running, wraps silently: no event is derived from the carry
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         time_base <= 64'h0;
      end else if (i_bus.wr && i_bus.addr == REG_TB_LO) begin
         time_base[31:0] <= i_bus.wdata;
      end else if (i_bus.wr && i_bus.addr == REG_TB_HI) begin
         time_base[63:32] <= i_bus.wdata;
      end else if (tick) begin
         time_base <= time_base + 64'h1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         ctrl <= CTRL_RESET;
      end else if (i_bus.wr && i_bus.addr == REG_CTRL) begin
         ctrl <= i_bus.wdata;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         mask <= '0;
      end else if (i_bus.wr && i_bus.addr == REG_MASK) begin
         mask <= i_bus.wdata[ST_W-1:0];
      end
   end

   // Interval counter steps on the shared tick; holds at zero
   assign idc_event = tick && interval_down_counter == 32'h1;

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         interval_down_counter <= 32'h0;
         reload_value          <= 32'h0;
      end else if (i_bus.wr && i_bus.addr == REG_IDC) begin
         interval_down_counter <= i_bus.wdata;
         reload_value          <= i_bus.wdata;
      end else if (idc_event && ctrl[CTRL_RELOAD]) begin
         interval_down_counter <= reload_value;
      end else if (tick && interval_down_counter != 32'h0) begin
         interval_down_counter <= interval_down_counter - 32'h1;
      end
   end

   // Tap selection for the two bit-watching timers
   always_comb begin
      case (ctrl[CTRL_FPT_SEL +: 2])
         2'h0:    fpt_bit = time_base[FPT_TAP0];
         2'h1:    fpt_bit = time_base[FPT_TAP1];
         2'h2:    fpt_bit = time_base[FPT_TAP2];
         default: fpt_bit = time_base[FPT_TAP3];
      endcase
      case (ctrl[CTRL_LGT_SEL +: 2])
         2'h0:    lgt_bit = time_base[LGT_TAP0];
         2'h1:    lgt_bit = time_base[LGT_TAP1];
         2'h2:    lgt_bit = time_base[LGT_TAP2];
         default: lgt_bit = time_base[LGT_TAP3];
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         fpt_bit_q <= 1'b0;
         lgt_bit_q <= 1'b0;
      end else begin
         fpt_bit_q <= fpt_bit;
         lgt_bit_q <= lgt_bit;
      end
   end

   // Only a 0 to 1 transition counts; falling edges are ignored
   assign fpt_event = fpt_bit & ~fpt_bit_q;
   assign lgt_event = lgt_bit & ~lgt_bit_q & ctrl[CTRL_LGT_EN];

   assign guard_clear = i_bus.wr && i_bus.addr == REG_GUARD && i_bus.wdata[GUARD_CLR];

   // Two intervals without a clear end in the selected reset
   always_ff @(posedge i_clock) begin
      if (i_srst || !ctrl[CTRL_LGT_EN]) begin
         lgt_state <= LGT_IDLE;
      end else begin
         case (lgt_state)
            LGT_IDLE: begin
               if (lgt_event) begin
                  lgt_state <= LGT_FIRST;
               end
            end
            LGT_FIRST: begin
               if (guard_clear) begin
                  lgt_state <= LGT_IDLE;
               end else if (lgt_event) begin
                  lgt_state <= LGT_SECOND;
               end
            end
            LGT_SECOND: begin
               lgt_state <= LGT_SECOND;
            end
            default: begin
               lgt_state <= LGT_IDLE;
            end
         endcase
      end
   end

   // Reset request is held until the core reset takes effect
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_reset_req  <= 1'b0;
         o_reset_kind <= 2'h0;
      end else if (lgt_state == LGT_FIRST && lgt_event && !guard_clear
                   && ctrl[CTRL_RST_KIND +: 2] != 2'(RST_NONE)) begin
         o_reset_req  <= 1'b1;
         o_reset_kind <= ctrl[CTRL_RST_KIND +: 2];
      end
   end

   assign rd_status = i_bus.rd && i_bus.addr == REG_STATUS;

   // Sticky flags; a new event in the clearing read's cycle survives
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         status <= '0;
      end else begin
         status <= (rd_status ? '0 : status) | {lgt_event, fpt_event, idc_event};
      end
   end

   // Critical-class guard interrupt kept apart from the ordinary line
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_irq          <= 1'b0;
         o_critical_irq <= 1'b0;
      end else begin
         o_irq          <= |(status[ST_FPT:ST_IDC] & mask[ST_FPT:ST_IDC]);
         o_critical_irq <= status[ST_LGT] & mask[ST_LGT];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_rdata <= '0;
      end else if (i_bus.rd) begin
         case (i_bus.addr)
            REG_CTRL:   o_rdata <= ctrl;
            REG_TB_LO:  o_rdata <= time_base[31:0];
            REG_TB_HI:  o_rdata <= time_base[63:32];
            REG_IDC:    o_rdata <= interval_down_counter;
            REG_STATUS: o_rdata <= {{(DATA_W-ST_W){1'b0}}, status};
            REG_MASK:   o_rdata <= {{(DATA_W-ST_W){1'b0}}, mask};
            REG_GUARD:  o_rdata <= {30'h0, lgt_state == LGT_SECOND, lgt_state == LGT_FIRST};
            default:    o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end
endmodule
`default_nettype wire

// >>> test/ctt_timers_assertions.sv
// Checker of the register port, interrupt and reset outputs
`default_nettype none
module ctt_timers_checker
   import ctt_pkg::*;
(
   input wire logic              i_clock,
   input wire logic              i_srst,
   input wire logic              i_ext_tick_clk,
   input wire ctt_bus_req_t      i_bus,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic              o_irq,
   input wire logic              o_critical_irq,
   input wire logic              o_reset_req,
   input wire logic [1:0]        o_reset_kind
);
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (i_srst);
   sequence s_lo_rd;
      i_bus.rd && i_bus.addr == REG_TB_LO;
   endsequence
   AST_TB_STEP: assert property (s_lo_rd ##1 s_lo_rd |=>
      (o_rdata - $past(o_rdata)) <= 32'h1) else $error("time base step");
   AST_RD_IDLE: assert property (!i_bus.rd |=> o_rdata == '0)
      else $error("read data outside read");
   AST_RD_WR: assert property (i_bus.wr |=> o_rdata == '0)
      else $error("read data after write");
   AST_UNMAP: assert property (i_bus.rd && i_bus.addr > REG_GUARD |=> o_rdata == '0)
      else $error("unmapped read");
   AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(i_bus.rd || i_bus.wr, 2))
      else $error("irq dropped without access");
   AST_CIRQ_FALL: assert property ($fell(o_critical_irq) |-> $past(i_bus.rd || i_bus.wr, 2))
      else $error("critical irq dropped without access");
   AST_RST_HOLD: assert property (o_reset_req |=> o_reset_req && $stable(o_reset_kind))
      else $error("reset request not held");
   AST_RST_KIND: assert property (o_reset_req |-> o_reset_kind != RST_NONE)
      else $error("reset request of kind none");
endmodule
bind ctt_timers ctt_timers_checker ctt_timers_checker_i (.i_clock(i_clock), .i_srst(i_srst),
   .i_ext_tick_clk(i_ext_tick_clk), .i_bus(i_bus), .o_rdata(o_rdata), .o_irq(o_irq),
   .o_critical_irq(o_critical_irq), .o_reset_req(o_reset_req), .o_reset_kind(o_reset_kind));
`default_nettype wire

// >>> test/tb_ctt_timers.sv
// Self-checking bench of the timebase and timers block
`default_nettype none
module tb_ctt_timers
   import ctt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              i_clock = 1'b0;
   logic              i_srst = 1'b1;
   logic              i_ext_tick_clk = 1'b0;
   ctt_bus_req_t      i_bus = '0;
   logic [DATA_W-1:0] o_rdata;
   logic              o_irq;
   logic              o_critical_irq;
   logic              o_reset_req;
   logic [1:0]        o_reset_kind;
   logic [31:0]       d;
   logic [31:0]       t;
   int                n_mismatch = 0;
   int                n_tests = 0;
   int                cyc = 0;
   int                n, c, s, k, tp;
   ctt_timers ctt_timers_i (.i_clock(i_clock), .i_srst(i_srst), .i_ext_tick_clk(i_ext_tick_clk),
      .i_bus(i_bus), .o_rdata(o_rdata), .o_irq(o_irq), .o_critical_irq(o_critical_irq),
      .o_reset_req(o_reset_req), .o_reset_kind(o_reset_kind));
   initial begin
      forever #4 i_clock = ~i_clock;
   end
   task automatic results();
      $display("mismatches %0d tests %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Run length is under a thousand cycles; the ceiling of 20000 leaves ample slack
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         results();
      end
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] v);
      n_tests++;
      if (v !== e) begin
         n_mismatch++;
         $display("unexpected %s exp %h got %h", nm, e, v);
      end
   endtask
   // Each access leaves a gap cycle so no strobe is assigned twice in one step
   task automatic wr(logic [3:0] a, logic [31:0] v);
      @(posedge i_clock);
      i_bus <= '{a, v, 1'b1, 1'b0};
      @(posedge i_clock);
      i_bus <= '0;
   endtask
   task automatic rd(logic [3:0] a);
      @(posedge i_clock);
      i_bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge i_clock);
      i_bus <= '0;
      #1 d = o_rdata;
   endtask
   task automatic wt(int m);
      repeat (m) @(posedge i_clock);
      #1;
   endtask
   function automatic int tap(int b, int sel);
      return b + 4 * sel;
   endfunction
   // Park the tapped bit low, then let it rise a few ticks later
   task automatic rise(int b);
      wr(REG_TB_LO, 32'h0);
      wr(REG_TB_LO, (32'h1 << b) - 32'h8);
      wt(12);
   endtask
   initial begin
      n = $urandom(82738);
      wt(12);
      i_srst <= 1'b0;
      rd(REG_CTRL);
      chk("ctrl", CTRL_RESET, d);
      rd(4'hf);
      chk("unmapped", 32'h0, d);
      n = $urandom_range(20, 1);
      rd(REG_TB_LO);
      t = d;
      wt(n);
      rd(REG_TB_LO);
      chk("tb step", t + n + 2, d);
      // Two one-cycle reads of the low word with no gap
      @(posedge i_clock);
      i_bus <= '{REG_TB_LO, 32'h0, 1'b0, 1'b1};
      @(posedge i_clock);
      i_bus <= '{REG_TB_LO, 32'h0, 1'b0, 1'b1};
      @(posedge i_clock);
      i_bus <= '0;
      wr(REG_MASK, 32'h7);
      wr(REG_TB_HI, 32'hffff_ffff);
      wr(REG_TB_LO, 32'hffff_fff0);
      wt(4);
      rd(REG_STATUS);
      wt(30);
      rd(REG_TB_HI);
      chk("tb wrap", 32'h0, d);
      rd(REG_STATUS);
      chk("wrap status", 32'h0, d);
      wr(REG_CTRL, 32'h3);
      rd(REG_TB_LO);
      t = d;
      for (c = 0; c < n; c++) begin
         i_ext_tick_clk <= 1'b1;
         wt(3);
         i_ext_tick_clk <= 1'b0;
         wt(3);
      end
      wt(4);
      rd(REG_TB_LO);
      chk("ext ticks", t + n, d);
      n = $urandom_range(40, 4);
      wr(REG_CTRL, 32'h1);
      wr(REG_MASK, 32'h1);
      rd(REG_STATUS);
      wr(REG_IDC, n);
      for (c = 0; c < 100 && o_irq !== 1'b1; c++) wt(1);
      chk("idc delay", n + 1, c);
      rd(REG_STATUS);
      chk("idc event", 32'h1, d & 32'h1);
      wt(n + 8);
      rd(REG_STATUS);
      chk("idc stopped", 32'h0, d & 32'h1);
      wr(REG_CTRL, 32'h5);
      wr(REG_IDC, n);
      wt(2 * n + 10);
      rd(REG_STATUS);
      wt(n + 4);
      rd(REG_STATUS);
      chk("idc reload", 32'h1, d & 32'h1);
      for (s = 0; s < 4; s++) begin
         tp = tap(FPT_TAP0, s);
         wr(REG_CTRL, 32'h1 | (s << CTRL_FPT_SEL));
         wr(REG_MASK, 32'h2);
         rd(REG_STATUS);
         rise(tp);
         chk("fpt irq", 32'h1, {31'h0, o_irq});
         wr(REG_MASK, 32'h0);
         wt(2);
         chk("masked irq", 32'h0, {31'h0, o_irq});
         rd(REG_STATUS);
         chk("fpt sticky", 32'h2, d & 32'h2);
         wr(REG_MASK, 32'h2);
         wr(REG_TB_LO, (32'h2 << tp) - 32'h8);
         wt(12);
         rd(REG_STATUS);
         chk("fpt fall", 32'h0, d & 32'h2);
      end
      s = $urandom_range(3, 0);
      k = $urandom_range(3, 1);
      tp = tap(LGT_TAP0, s);
      wr(REG_CTRL, 32'h101 | (s << CTRL_LGT_SEL) | (k << CTRL_RST_KIND));
      wr(REG_MASK, 32'h4);
      rd(REG_STATUS);
      rise(tp);
      chk("guard irq", 32'h1, {31'h0, o_critical_irq});
      rd(REG_GUARD);
      chk("guard first", 32'h1, d & 32'h1);
      wr(REG_GUARD, 32'h1);
      rise(tp);
      chk("guard cleared", 32'h0, {31'h0, o_reset_req});
      rise(tp);
      chk("guard reset", 32'h1, {31'h0, o_reset_req});
      chk("reset kind", k, {30'h0, o_reset_kind});
      rd(REG_STATUS);
      wt(1);
      chk("guard irq clear", 32'h0, {31'h0, o_critical_irq});
      results();
   end
endmodule
`default_nettype wire
